// >>> rtl/acr_ctrl.sv
// Purpose: Register file, trigger logic and conversion sequencer of a
//          10-bit successive-approximation converter.
// Assumes: Analog core returns a 10-bit sample, taken when the count of conversion clock periods ends;
//          trigger inputs are asynchronous levels.
// Notes:   Conversion clock rates are enables divided from ref_clk_i or taken from rc_tick_i.
`timescale 1ns/100ps
`include "acr_params.svh"

// Overview of operation
// - Channel field bits 7:2 routes input; 100101 fixed ref, 100100 ground.
// - Codes 011000 to 100010 valid only on large packages, else none.
// - Writing go bit starts conversion; go reads one while converting.
// - Hardware clears go bit when conversion finishes.
// - Enable bit turns converter on; clear means off, no current.
// - Format set right-justifies, upper six high-byte bits zero.
// - Format clear left-justifies, lower six low-byte bits zero.
// - Clock field picks oscillator divider or dedicated RC clock.
// - Reference field picks supply, pin, or fixed reference; 01 reserved.
// - Trigger field selects auto-conversion source codes 0000 to 1001.
// - Code 1101 makes a read of result high byte a trigger.
// - 16-bit result at 0x09b resets zero; bytes separately addressable.
// - Control 0 at 0x09d, control 1 at 0x09e, trigger at 0x09f.
// - Control 1 resets to zero; bits 3:2 hold no state.
// - Completion clears go, sets interrupt flag, loads new result.
// - Rising edge of selected trigger sets go bit in hardware.
module acr_ctrl #(
   parameter bit LARGE_PKG = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic [7:0] addr_i,
   input wire logic [7:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   input wire logic [9:1] trig_src_i,
   input wire logic rc_tick_i,
   input wire logic [9:0] sample_i,
   output logic [5:0] chan_sel_o,
   output logic chan_valid_o,
   output acr_pkg::acr_ref_t ref_sel_o,
   output logic core_on_o,
   output logic sample_o,
   output logic conv_done_o,
   output logic irq_o
);
   import acr_pkg::*;

   // ==========================================================
   // Registers
   logic [5:0] chan_ff;
   logic go_ff;
   logic on_ff;
   logic fmt_ff;
   logic [2:0] clk_sel_ff;
   logic [1:0] ref_ff;
   logic [3:0] trig_ff;
   logic [15:0] res_ff;
   logic irq_stat_ff;
   logic irq_en_ff;
   logic [7:0] rdata_ff;
   acr_state_t state_ff;
   acr_state_t nxt_state;
   logic [7:0] tad_cnt_ff;
   logic [5:0] div_cnt_ff;
   logic [8:0] sync1_ff;
   logic [8:0] sync2_ff;
   logic [8:0] sync3_ff;
   logic rc1_ff;
   logic rc2_ff;
   logic rc3_ff;
   logic [5:0] chan_o_ff;
   logic chan_v_ff;
   logic [1:0] ref_o_ff;
   logic on_o_ff;
   logic smp_ff;
   logic done_ff;
   logic irq_ff;

   // ==========================================================
   // Decode
   wire wr_res_lo = wr_i && (addr_i == `ACR_OFS_RES_LO);
   wire wr_res_hi = wr_i && (addr_i == `ACR_OFS_RES_HI);
   wire wr_ctrl0 = wr_i && (addr_i == `ACR_OFS_CTRL0);
   wire wr_ctrl1 = wr_i && (addr_i == `ACR_OFS_CTRL1);
   wire wr_trig = wr_i && (addr_i == `ACR_OFS_TRIG);
   wire wr_iclr = wr_i && (addr_i == `ACR_OFS_IRQ_CLR);
   wire wr_ien = wr_i && (addr_i == `ACR_OFS_IRQ_EN);
   wire rd_res_hi = rd_i && (addr_i == `ACR_OFS_RES_HI);

   // Justification of the fresh sample
   function automatic logic [15:0] justify(input logic fmt,
                                           input logic [9:0] s);
      justify = fmt ? {6'h00, s} : {s, 6'h00};
   endfunction : justify

   // Reserved channels map to no input
   function automatic logic chan_ok(input logic [5:0] c,
                                    input logic big);
      logic ok;
      ok = 1'b0;
      if (c <= 6'h0d && c != 6'h04 && c != 6'h06 && c != 6'h07) begin
         ok = 1'b1;
      end
      if (c >= 6'h12 && c <= 6'h17) begin
         ok = 1'b1;
      end
      if (c >= `ACR_CHS_BIG_LO && c <= `ACR_CHS_BIG_HI) begin
         ok = big;
      end
      if (c == `ACR_CHS_FVR || c == `ACR_CHS_GND) begin
         ok = 1'b1;
      end
      chan_ok = ok;
   endfunction : chan_ok

   // ==========================================================
   // Trigger selection; sync2 feeds edge detect, sync1 only sync2
   wire [15:0] trig_lvl = {6'h00, sync2_ff, 1'b0};
   wire [15:0] trig_old = {6'h00, sync3_ff, 1'b0};
   wire trig_known = (trig_ff <= `ACR_TRIG_MAX);
   wire hw_edge = trig_known && trig_lvl[trig_ff] &&
                  !trig_old[trig_ff];
   wire rd_trig = (trig_ff == `ACR_TRIG_RDHI) && rd_res_hi;
   wire sw_go = wr_ctrl0 && wdata_i[`ACR_GO_BIT];
   // a go written with the enable in one write is dropped, as on_ff
   // is still clear; software is expected to set the enable first.
   wire start = on_ff && !go_ff && (sw_go || hw_edge || rd_trig);

   // ==========================================================
   // Conversion clock enable
   wire rc_tick = rc2_ff && !rc3_ff;
   logic [5:0] div_max;
   always_comb begin
      unique case (clk_sel_ff)
         3'h0: div_max = 6'd1;
         3'h1: div_max = 6'd7;
         3'h2: div_max = 6'd31;
         3'h4: div_max = 6'd3;
         3'h5: div_max = 6'd15;
         3'h6: div_max = 6'd63;
         default: div_max = 6'd0;
      endcase
   end
   wire use_rc = (clk_sel_ff == 3'h3) || (clk_sel_ff == 3'h7);
   wire div_tick = (div_cnt_ff >= div_max);
   wire tad = use_rc ? rc_tick : div_tick;

   // ==========================================================
   // Sequencer
   wire finish = (state_ff == ACR_RUN) && tad && (tad_cnt_ff == 8'd0);
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         ACR_IDLE: if (start) nxt_state = ACR_RUN;
         ACR_RUN: begin
            if (!on_ff) begin
               nxt_state = ACR_IDLE;
            end else if (finish) begin
               nxt_state = ACR_DONE;
            end
         end
         ACR_DONE: nxt_state = ACR_IDLE;
         default: nxt_state = ACR_IDLE;
      endcase
   end
   wire done_evt = (state_ff == ACR_DONE);

   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_ff <= ACR_IDLE;
         tad_cnt_ff <= 8'd0;
         div_cnt_ff <= 6'd0;
      end else begin
         state_ff <= nxt_state;
         div_cnt_ff <= div_tick ? 6'd0 : div_cnt_ff + 6'd1;
         if (state_ff == ACR_IDLE) begin
            tad_cnt_ff <= `ACR_CONV_TAD;
         end else if (tad && tad_cnt_ff != 8'd0) begin
            tad_cnt_ff <= tad_cnt_ff - 8'd1;
         end
      end
   end

   // ==========================================================
   // Control registers
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         chan_ff <= 6'h00;
         on_ff <= 1'b0;
         go_ff <= 1'b0;
         fmt_ff <= 1'b0;
         clk_sel_ff <= 3'h0;
         ref_ff <= 2'h0;
         trig_ff <= `ACR_TRIG_RST;
      end else begin
         if (wr_ctrl0) begin
            chan_ff <= wdata_i[7:2];
            on_ff <= wdata_i[`ACR_ON_BIT];
         end
         if (start) begin
            go_ff <= 1'b1;
         end else if (done_evt || (state_ff == ACR_RUN && !on_ff)) begin
            go_ff <= 1'b0;
         end
         if (wr_ctrl1) begin
            fmt_ff <= wdata_i[`ACR_FMT_BIT];
            clk_sel_ff <= wdata_i[6:4];
            ref_ff <= wdata_i[1:0];
         end
         if (wr_trig) begin
            trig_ff <= wdata_i[3:0];
         end
      end
   end

   // ==========================================================
   // Result and interrupt; hardware set wins over clear
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         res_ff <= `ACR_RES_RST;
         irq_stat_ff <= 1'b0;
         irq_en_ff <= 1'b0;
      end else begin
         if (done_evt) begin
            res_ff <= justify(fmt_ff, sample_i);
         end else begin
            if (wr_res_lo) res_ff[7:0] <= wdata_i;
            if (wr_res_hi) res_ff[15:8] <= wdata_i;
         end
         if (done_evt) begin
            irq_stat_ff <= 1'b1;
         end else if (wr_iclr && wdata_i[0]) begin
            irq_stat_ff <= 1'b0;
         end
         if (wr_ien) irq_en_ff <= wdata_i[0];
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   logic [7:0] rd_mux;
   always_comb begin
      unique case (addr_i)
         `ACR_OFS_RES_LO: rd_mux = res_ff[7:0];
         `ACR_OFS_RES_HI: rd_mux = res_ff[15:8];
         `ACR_OFS_CTRL0: rd_mux = {chan_ff, go_ff, on_ff};
         `ACR_OFS_CTRL1: rd_mux = {fmt_ff, clk_sel_ff, 2'b00, ref_ff};
         `ACR_OFS_TRIG: rd_mux = {4'h0, trig_ff};
         `ACR_OFS_IRQ_STAT: rd_mux = {7'h00, irq_stat_ff};
         `ACR_OFS_IRQ_EN: rd_mux = {7'h00, irq_en_ff};
         default: rd_mux = 8'h00;
      endcase
   end

   // ==========================================================
   // Synchronisers and outputs
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         sync1_ff <= 9'h000;
         sync2_ff <= 9'h000;
         sync3_ff <= 9'h000;
         rc1_ff <= 1'b0;
         rc2_ff <= 1'b0;
         rc3_ff <= 1'b0;
         rdata_ff <= 8'h00;
         chan_o_ff <= 6'h00;
         chan_v_ff <= 1'b0;
         ref_o_ff <= 2'h0;
         on_o_ff <= 1'b0;
         smp_ff <= 1'b0;
         done_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         sync1_ff <= trig_src_i;
         sync2_ff <= sync1_ff;
         sync3_ff <= sync2_ff;
         rc1_ff <= rc_tick_i;
         rc2_ff <= rc1_ff;
         rc3_ff <= rc2_ff;
         rdata_ff <= rd_i ? rd_mux : 8'h00;
         chan_o_ff <= chan_ff;
         chan_v_ff <= on_ff && chan_ok(chan_ff, LARGE_PKG);
         ref_o_ff <= ref_ff;
         on_o_ff <= on_ff;
         smp_ff <= (state_ff == ACR_RUN);
         done_ff <= done_evt;
         irq_ff <= irq_en_ff && (irq_stat_ff || done_evt);
      end
   end

   assign rdata_o = rdata_ff;
   assign chan_sel_o = chan_o_ff;
   assign chan_valid_o = chan_v_ff;
   assign ref_sel_o = acr_ref_t'(ref_o_ff);
   assign core_on_o = on_o_ff;
   assign sample_o = smp_ff;
   assign conv_done_o = done_ff;
   assign irq_o = irq_ff;

   // ==========================================================
   // Checks
   sequence s_done;
      state_ff == ACR_DONE;
   endsequence

   chk_done_clears_go: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) s_done |=> !go_ff)
      else $error("go not cleared after completion");
   chk_done_sets_flag: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) s_done |=> irq_stat_ff)
      else $error("flag not set on completion");
   chk_go_busy: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (state_ff == ACR_RUN) |-> go_ff)
      else $error("go low while converting");
   chk_start_go: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) start |=> go_ff && state_ff == ACR_RUN)
      else $error("start did not set go");
   chk_rsvd_trig: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (!trig_known && !sw_go && !rd_trig && !go_ff)
      |=> !go_ff)
      else $error("reserved trigger fired");
   chk_right_just: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (s_done ##0 fmt_ff) |=> res_ff[15:10] == 6'h00)
      else $error("right justify high bits not zero");
   chk_left_just: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (s_done ##0 !fmt_ff) |=> res_ff[5:0] == 6'h00)
      else $error("left justify low bits not zero");
   chk_off_no_go: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (!on_ff && !go_ff) |=> !go_ff)
      else $error("start while disabled");
   chk_rd_trig: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (rd_trig && on_ff && !go_ff) |=> go_ff)
      else $error("high byte read did not trigger");

   // ==========================================================
   // Bus, output and abort checks
   sequence s_abort;
      state_ff == ACR_RUN && !on_ff;
   endsequence

   chk_ctrl1_gap: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (rd_i && addr_i == `ACR_OFS_CTRL1)
      |=> rdata_o[3:2] == 2'b00)
      else $error("unimplemented control 1 bits read as one");
   chk_rdata_idle: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) !rd_i |=> rdata_o == 8'h00)
      else $error("read data without a read strobe");
   chk_fixed_chan: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (on_ff && (chan_ff == `ACR_CHS_GND ||
      chan_ff == `ACR_CHS_FVR)) |=> chan_valid_o)
      else $error("ground or fixed reference channel not valid");
   chk_big_chan: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (on_ff && chan_ff >= `ACR_CHS_BIG_LO &&
      chan_ff <= `ACR_CHS_BIG_HI) |=> chan_valid_o == LARGE_PKG)
      else $error("large package channel validity wrong");
   chk_done_pulse: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) s_done |=> conv_done_o ##1 !conv_done_o)
      else $error("done pulse not one cycle");
   chk_abort_flag: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (s_abort ##0 !irq_stat_ff)
      |=> !irq_stat_ff && !go_ff)
      else $error("aborted conversion set flag or kept go");
   chk_sample_out: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (state_ff == ACR_RUN) |=> sample_o)
      else $error("sample output low while converting");
   chk_irq_level: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (irq_en_ff && irq_stat_ff) |=> irq_o)
      else $error("enabled flag without interrupt");
   chk_result_hold: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (state_ff != ACR_DONE && !wr_res_lo &&
      !wr_res_hi) |=> $stable(res_ff))
      else $error("result changed without a cause");
   chk_flag_clear: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) (wr_iclr && wdata_i[0] && state_ff != ACR_DONE)
      |=> !irq_stat_ff)
      else $error("flag not cleared by software");
   chk_off_outputs: assert property (@(posedge ref_clk_i)
      disable iff (rst_i) !on_ff |=> !core_on_o && !chan_valid_o)
      else $error("outputs on while disabled");

endmodule : acr_ctrl

// >>> rtl/acr_params.svh
// Purpose: Offsets, field positions, reset values and counts of the
//          converter control block.
// Assumes: Byte-wide register port with an 8-bit address.
// Notes:   Definitions only.
`ifndef ACR_PARAMS_SVH
`define ACR_PARAMS_SVH

// ==========================================================
// Register offsets
`define ACR_OFS_RES_LO 8'h9b
`define ACR_OFS_RES_HI 8'h9c
`define ACR_OFS_CTRL0 8'h9d
`define ACR_OFS_CTRL1 8'h9e
`define ACR_OFS_TRIG 8'h9f
`define ACR_OFS_IRQ_STAT 8'ha0
`define ACR_OFS_IRQ_CLR 8'ha1
`define ACR_OFS_IRQ_EN 8'ha2

// ==========================================================
// Field positions
`define ACR_GO_BIT 1
`define ACR_ON_BIT 0
`define ACR_FMT_BIT 7

// ==========================================================
// Reset values
`define ACR_CTRL0_RST 8'h00
`define ACR_CTRL1_RST 8'h00
`define ACR_TRIG_RST 4'h0
`define ACR_RES_RST 16'h0000

// ==========================================================
// Channel codes
`define ACR_CHS_FVR 6'h25
`define ACR_CHS_GND 6'h24
`define ACR_CHS_BIG_LO 6'h18
`define ACR_CHS_BIG_HI 6'h22

// ==========================================================
// Trigger codes
`define ACR_TRIG_MAX 4'h9
`define ACR_TRIG_RDHI 4'hd

// ==========================================================
// Conversion timing in conversion clock periods
`define ACR_CONV_TAD 8'd11

`endif

// >>> rtl/acr_pkg.sv
// Purpose: Types of the converter control block.
// Assumes: Used together with acr_params.svh.
// Notes:   Types only.
package acr_pkg;

   // ==========================================================
   // Conversion sequencer states, Gray along idle-run-done
   typedef enum logic [1:0] {
      ACR_IDLE = 2'b00,
      ACR_RUN = 2'b01,
      ACR_DONE = 2'b11
   } acr_state_t;

   // ==========================================================
   // Positive reference choice
   typedef enum logic [1:0] {
      ACR_REF_SUPPLY = 2'b00,
      ACR_REF_RSVD = 2'b01,
      ACR_REF_PIN = 2'b10,
      ACR_REF_FIXED = 2'b11
   } acr_ref_t;

endpackage : acr_pkg

// >>> tb/acr_core_model.sv
// Purpose: Stand-in for the analog core and the trigger sources.
// Assumes: The block reads the sample while sample_o is high.
// Notes:   Released sample lines show a moving pattern.
`timescale 1ns/100ps
module acr_core_model (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic converting_i,
   input wire logic [9:0] val_i,
   input wire logic [9:1] fire_i,
   output logic [9:0] sample_val_o,
   output logic [9:1] trig_o,
   output logic rc_tick_o
);
   logic [9:0] noise_ff;
   logic [9:1] src_ff;
   logic [2:0] hold_ff;
   // ==========================================================
   // RC oscillator, free running and unrelated in phase
   initial begin
      rc_tick_o = 1'b0;
      #17;
      forever #350 rc_tick_o = ~rc_tick_o;
   end
   // ==========================================================
   // Sample lines; garbage outside a conversion
   assign sample_val_o = converting_i ? val_i : noise_ff;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         noise_ff <= 10'h155;
      end else begin
         noise_ff <= {noise_ff[8:0], ~noise_ff[9]} ^ 10'h2a5;
      end
   end
   // ==========================================================
   // Trigger levels held long enough for the synchroniser
   assign trig_o = src_ff;
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         src_ff <= 9'h000;
         hold_ff <= 3'h0;
      end else if (fire_i != 9'h000) begin
         src_ff <= fire_i;
         hold_ff <= 3'h4;
      end else if (hold_ff != 3'h0) begin
         hold_ff <= hold_ff - 3'h1;
      end else begin
         src_ff <= 9'h000;
      end
   end
endmodule : acr_core_model

// >>> tb/acr_ctrl_tb.sv
// Purpose: Self-checking bench of the converter control block.
// Assumes: Read data stands in the cycle after the read strobe.
// Notes:   Read results are checked from a queue of expectations.
`timescale 1ns/100ps
`include "acr_params.svh"
module acr_ctrl_tb;
   import acr_pkg::*;
   typedef struct {bit chk; logic [7:0] exp; string nm;} acr_note_t;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic rd_seen = 1'b0;
   logic [9:0] val = 10'h000;
   logic [9:1] fire = 9'h000;
   logic [7:0] rdata, rv;
   logic [9:1] trig;
   logic rc_tick, smp, done, irq, on, cvalid;
   logic [9:0] sample;
   logic [5:0] chan;
   acr_ref_t rsel;
   acr_note_t q[$];
   int n_mismatch = 0;
   int cmp_count = 0;
   int cyc = 0;
   int n_done = 0;
   logic [7:0] rst_addr [8] = '{8'h9b, 8'h9c, 8'h9d, 8'h9e, 8'h9f,
      8'ha0, 8'ha2, 8'h80};
   logic [5:0] input_channel_select [9] = '{6'h25, 6'h24, 6'h23, 6'h18, 6'h22, 6'h26,
      6'h04, 6'h00, 6'h3f};
   logic chv [9] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0};
   int dv [8] = '{2, 8, 32, 14, 4, 16, 64, 14};

   acr_ctrl #(.LARGE_PKG(1'b1)) acr_ctrl_i (.ref_clk_i(ref_clk_i),
      .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .rdata_o(rdata), .trig_src_i(trig), .rc_tick_i(rc_tick),
      .sample_i(sample), .chan_sel_o(chan), .chan_valid_o(cvalid),
      .ref_sel_o(rsel), .core_on_o(on), .sample_o(smp),
      .conv_done_o(done), .irq_o(irq));
   acr_core_model acr_core_model_i (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .converting_i(smp), .val_i(val), .fire_i(fire),
      .sample_val_o(sample), .trig_o(trig), .rc_tick_o(rc_tick));

   // ==========================================================
   // Clock, cycle count and result watcher
   always #25 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      cyc <= cyc + 1;
      rd_seen <= rd;
      if (done === 1'b1) n_done <= n_done + 1;
   end
   always @(negedge ref_clk_i) begin
      acr_note_t n;
      if (rd_seen) begin
         n = q.pop_front();
         if (n.chk) check(n.nm, {8'h00, rdata}, {8'h00, n.exp});
      end
   end

   // ==========================================================
   // Tasks
   task automatic check(input string nm, input logic [15:0] seen,
      input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge ref_clk_i);
      wr <= 1'b0;
   endtask : wr_reg
   task automatic rd_reg(input logic [7:0] a, input bit chk,
      input logic [7:0] e, input string nm);
      q.push_back('{chk, e, nm});
      @(posedge ref_clk_i);
      addr <= a;
      rd <= 1'b1;
      @(posedge ref_clk_i);
      rd <= 1'b0;
      @(negedge ref_clk_i);
      rv = rdata;
   endtask : rd_reg
   task automatic exp_rd(input logic [7:0] a, input logic [7:0] e,
      input string nm);
      rd_reg(a, 1'b1, e, nm);
   endtask : exp_rd
   task automatic settle();
      repeat (2) @(posedge ref_clk_i);
      @(negedge ref_clk_i);
   endtask : settle
   // Bounded poll; a stuck go bit counts as a mismatch
   task automatic wait_idle();
      int n;
      n = 0;
      rd_reg(`ACR_OFS_CTRL0, 1'b0, 8'h00, "");
      while (rv[`ACR_GO_BIT] !== 1'b0 && n < 600) begin
         rd_reg(`ACR_OFS_CTRL0, 1'b0, 8'h00, "");
         n++;
      end
      if (n >= 600) check("conversion end", 16'h1, 16'h0);
   endtask : wait_idle
   task automatic pulse(input logic [9:1] m);
      @(posedge ref_clk_i);
      fire <= m;
      @(posedge ref_clk_i);
      fire <= 9'h000;
      repeat (8) @(posedge ref_clk_i);
   endtask : pulse
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : give_verdict

   // ==========================================================
   // Watchdog, far beyond the expected run length
   initial begin
      repeat (20000) @(posedge ref_clk_i);
      n_mismatch++;
      give_verdict();
   end

   // ==========================================================
   // Tests
   initial begin
      logic [9:0] s;
      logic [9:1] sel;
      int t0;
      int nd;
      void'($urandom(82));
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      foreach (rst_addr[i]) exp_rd(rst_addr[i], 8'h00, "reset");
      s = 10'($urandom_range(0, 1023));
      wr_reg(`ACR_OFS_RES_LO, s[7:0]);
      wr_reg(`ACR_OFS_RES_HI, ~s[7:0]);
      wr_reg(`ACR_OFS_IRQ_STAT, 8'hff);
      exp_rd(`ACR_OFS_RES_LO, s[7:0], "result low");
      exp_rd(`ACR_OFS_RES_HI, ~s[7:0], "result high");
      exp_rd(`ACR_OFS_IRQ_STAT, 8'h00, "status");
      $display("test register map done");
      for (int r = 0; r < 4; r++) begin
         wr_reg(`ACR_OFS_CTRL1, 8'hfc | r[7:0]);
         settle();
         check("reference", {14'h0, rsel}, r[15:0]);
         exp_rd(`ACR_OFS_CTRL1, 8'hf0 | r[7:0], "control 1");
      end
      foreach (input_channel_select[i]) begin
         wr_reg(`ACR_OFS_CTRL0, {input_channel_select[i], 2'b01});
         settle();
         check("channel", {10'h0, chan}, {10'h0, input_channel_select[i]});
         check("channel valid", {15'h0, cvalid}, {15'h0, chv[i]});
         check("enable", {15'h0, on}, 16'h1);
         exp_rd(`ACR_OFS_CTRL0, {input_channel_select[i], 2'b01}, "control 0");
      end
      wr_reg(`ACR_OFS_CTRL0, 8'h96);
      settle();
      check("disabled", {14'h0, on, cvalid}, 16'h0);
      exp_rd(`ACR_OFS_CTRL0, 8'h94, "go while off");
      exp_rd(`ACR_OFS_IRQ_STAT, 8'h00, "aborted status");
      wr_reg(`ACR_OFS_CTRL0, 8'h01);
      exp_rd(`ACR_OFS_CTRL0, 8'h01, "enable first");
      $display("test control fields done");
      wr_reg(`ACR_OFS_IRQ_EN, 8'h01);
      for (int cs = 0; cs < 8; cs++) begin
         s = 10'($urandom_range(0, 1023));
         val <= s;
         wr_reg(`ACR_OFS_CTRL1, {cs[0], cs[2:0], 4'h0});
         nd = n_done;
         wr_reg(`ACR_OFS_CTRL0, 8'h03);
         t0 = cyc;
         exp_rd(`ACR_OFS_CTRL0, 8'h03, "busy");
         check("sampling", {15'h0, smp}, 16'h1);
         wait_idle();
         check("sample end", {15'h0, smp}, 16'h0);
         check("done pulse", 16'(n_done - nd), 16'h1);
         t0 = cyc - t0;
         check("length", 16'(t0 >= 11 * dv[cs] && t0 <= 13 * dv[cs] + 12),
            16'h1);
         exp_rd(`ACR_OFS_RES_HI, cs[0] ? {6'h0, s[9:8]} : s[9:2],
            "high byte");
         exp_rd(`ACR_OFS_RES_LO, cs[0] ? s[7:0] : {s[1:0], 6'h00},
            "low byte");
         check("irq", {15'h0, irq}, 16'h1);
         exp_rd(`ACR_OFS_IRQ_STAT, 8'h01, "status");
         wr_reg(`ACR_OFS_IRQ_CLR, 8'h01);
         settle();
         check("irq cleared", {15'h0, irq}, 16'h0);
      end
      $display("test clock and format done");
      wr_reg(`ACR_OFS_IRQ_EN, 8'h00);
      wr_reg(`ACR_OFS_CTRL0, 8'h03);
      wait_idle();
      check("masked irq", {15'h0, irq}, 16'h0);
      exp_rd(`ACR_OFS_IRQ_STAT, 8'h01, "masked status");
      wr_reg(`ACR_OFS_IRQ_EN, 8'h01);
      settle();
      check("unmasked irq", {15'h0, irq}, 16'h1);
      $display("test interrupt mask done");
      wr_reg(`ACR_OFS_CTRL1, 8'h00);
      for (int c = 0; c < 16; c++) begin
         sel = (c >= 1 && c <= 9) ? 9'(9'h1 << (c - 1)) : 9'h000;
         wr_reg(`ACR_OFS_TRIG, c[7:0]);
         wr_reg(`ACR_OFS_IRQ_CLR, 8'h01);
         exp_rd(`ACR_OFS_TRIG, c[7:0], "trigger code");
         pulse(~sel);
         exp_rd(`ACR_OFS_CTRL0, 8'h01, "foreign trigger");
         pulse(sel);
         wait_idle();
         exp_rd(`ACR_OFS_IRQ_STAT, {7'h0, sel != 9'h0}, "trigger");
      end
      wr_reg(`ACR_OFS_TRIG, `ACR_TRIG_RDHI);
      wr_reg(`ACR_OFS_IRQ_CLR, 8'h01);
      rd_reg(`ACR_OFS_RES_HI, 1'b0, 8'h00, "");
      repeat (4) @(posedge ref_clk_i);
      wait_idle();
      exp_rd(`ACR_OFS_IRQ_STAT, 8'h01, "read trigger");
      $display("test triggers done");
      give_verdict();
   end
endmodule : acr_ctrl_tb
